// ### tbgi_pkg.sv
// Shared constants of the time base and grouped interrupt block.
// Assumes a 32-bit Avalon-MM slave with byte addresses on a 6-bit address.
package tbgi_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_PSC0 = 6'h00;
    localparam logic [5:0] ADDR_PSC1 = 6'h04;
    localparam logic [5:0] ADDR_TBC0 = 6'h08;
    localparam logic [5:0] ADDR_TBC1 = 6'h0c;
    localparam logic [5:0] ADDR_IRQ = 6'h10;
    localparam logic [5:0] ADDR_GRP0 = 6'h14;
    localparam logic [5:0] ADDR_GRP1 = 6'h18;
    localparam logic [5:0] ADDR_GRP2 = 6'h1c;
    localparam logic [5:0] ADDR_THR = 6'h20;

    // ----------------------------------------------------------------
    // Field positions and write masks
    // ----------------------------------------------------------------
    localparam int TBC_ON_BIT = 7;
    localparam int TBC_PRE_LSB = 4;
    localparam int TBC_PER_LSB = 0;
    localparam logic [7:0] TBC0_WMASK = 8'hf7;
    localparam logic [7:0] TBC1_WMASK = 8'h87;
    localparam int IRQ_GLOBAL_BIT = 0;
    localparam int IRQ_TICKEN_LSB = 1;
    localparam int IRQ_GRPEN_LSB = 3;
    localparam int IRQ_TICKF_LSB = 8;
    localparam int IRQ_GRPF_LSB = 10;
    localparam int GRP_FLAG_LSB = 4;
    localparam int GRP_EN_LSB = 0;
    // Implemented member bits: two each in groups 0 and 1, all three in group 2 in the top bits
    localparam logic [8:0] GRP_MEMBER_MASK = 9'h1db;

    // ----------------------------------------------------------------
    // Encodings, reset values, timing
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_SYS = 2'h0;
    localparam logic [1:0] SEL_DIV4 = 2'h1;
    localparam logic [1:0] PSC_RST = 2'h0;
    localparam logic [7:0] TBC_RST = 8'h00;
    localparam logic [7:0] THR_RST = 8'h00;
    localparam int PER_BASE = 8;
    localparam logic [1:0] DIV4_LAST = 2'h3;

    typedef enum logic [2:0] {
        TBGI_VEC_TICK0,
        TBGI_VEC_TICK1,
        TBGI_VEC_GRP0,
        TBGI_VEC_GRP1,
        TBGI_VEC_GRP2
    } tbgi_vec_t;

endpackage

// ### tbgi_core.sv
// Two periodic time bases and three grouped interrupt vectors with an Avalon-MM register slave.
// Assumes a core sequencer that acknowledges the shown vector and reports stack full and return.

// Function
// - Overflow of each time-base divider sets that time base's own request flag.
// - Time-base request vectors only with global enable, own enable, stack not full.
// - Taking a time-base interrupt clears its flag and the global enable.
// - Prescaler 0 source: 00 system clock, 01 system clock by four, 1x sub clock.
// - Prescaler 1 source uses the same three-way encoding.
// - In deepest sleep time base 0 runs from the low-speed oscillator.
// - Bit 7 of each time-base control turns it on; both reset off.
// - Time base 0 has pre-stage 2^0..2^7 and main period 2^8..2^15.
// - Time base 1 period field selects 2^8..2^15 prescaler cycles.
// - Three grouped vectors, each formed only from its member sources.
// - Any member flag setting sets its group request flag.
// - Group vectors only with global, group and member enables, stack not full.
// - Servicing a group clears its group flag and the global enable.
// - Transmit margin flag sets when fill length drops below threshold.
// - Margin request vectors only with own, global and group enables.
// - Burst-complete flag sets when a burst packet has been fully sent.
// - Burst-complete request vectors only with own, global and group enables.
// - Low-supply flag sets when the supply monitor reports low voltage.
// - Low-supply request vectors only with own, global and group enables.
// - Any request flag rising wakes the device, enabled or not.
// - Time base 0 can wake from deepest sleep on the low-speed oscillator.
// - Return from interrupt sets the global enable; plain return leaves it.
module tbgi_core #(
    parameter int TXLEN_W = 8
) (
    input logic i_mclk,
    input logic i_reset,
    input logic i_ce,
    input logic [5:0] i_avs_address,
    input logic i_avs_read,
    input logic i_avs_write,
    input logic [31:0] i_avs_writedata,
    input logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input logic i_sub_clock,
    input logic i_low_speed_osc,
    input logic i_deep_sleep,
    input logic [3:0] i_timer_match,
    input logic i_low_supply,
    input logic [TXLEN_W-1:0] i_tx_fill_len,
    input logic i_burst_done,
    input logic i_stack_full,
    input logic i_irq_ack,
    input logic i_return_from_irq,
    output logic o_irq_req,
    output tbgi_pkg::tbgi_vec_t o_irq_vector,
    output logic o_wake
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [1:0] psc_q [2];
    logic [7:0] tbc_q [2];
    logic global_q;
    logic [1:0] tick_en_q;
    logic [1:0] tick_flag_q;
    logic [2:0] grp_en_q;
    logic [2:0] grp_flag_q;
    logic [2:0] mem_flag_q [3];
    logic [2:0] mem_en_q [3];
    logic [2:0] mem_evt [3];
    logic [TXLEN_W-1:0] thr_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic req_q;
    tbgi_pkg::tbgi_vec_t vec_q;
    tbgi_pkg::tbgi_vec_t vec_d;
    logic wake_q;
    logic [2:0] sub_sync_q;
    logic [2:0] lirc_sync_q;
    logic [2:0] low_sync_q;
    logic margin_cond_q;
    logic [1:0] div4_q;
    logic sub_rise;
    logic lirc_rise;
    logic low_rise;
    logic margin_rise;
    logic div4_tick;
    logic [1:0] src_tick;
    logic [1:0] tb_ovf;
    logic [14:0] tb_cnt [2];
    logic wr_fire;
    logic [4:0] pend;
    logic [4:0] ack_hot;
    logic [2:0] grp_set;
    logic any_rise;

    assign wr_fire = i_avs_write && !wait_q;
    assign ack_hot = i_irq_ack ? 5'(5'h01 << vec_q) : 5'h00;

    // ----------------------------------------------------------------
    // Pin synchronisers and source edges
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            sub_sync_q <= 3'h0;
            lirc_sync_q <= 3'h0;
            low_sync_q <= 3'h0;
            margin_cond_q <= 1'b0;
            div4_q <= 2'h0;
        end else if (i_ce) begin
            sub_sync_q <= {sub_sync_q[1:0], i_sub_clock};
            lirc_sync_q <= {lirc_sync_q[1:0], i_low_speed_osc};
            low_sync_q <= {low_sync_q[1:0], i_low_supply};
            margin_cond_q <= i_tx_fill_len < thr_q;
            div4_q <= div4_q + 2'h1;
        end
    end

    assign sub_rise = sub_sync_q[1] && !sub_sync_q[2];
    assign lirc_rise = lirc_sync_q[1] && !lirc_sync_q[2];
    assign low_rise = low_sync_q[1] && !low_sync_q[2];
    assign margin_rise = (i_tx_fill_len < thr_q) && !margin_cond_q;
    assign div4_tick = div4_q == tbgi_pkg::DIV4_LAST;

    // Member events: groups 0 and 1 carry timer matches, group 2 the radio and supply
    assign mem_evt[0] = {1'b0, i_timer_match[1:0]};
    assign mem_evt[1] = {1'b0, i_timer_match[3:2]};
    assign mem_evt[2] = {low_rise, margin_rise, i_burst_done};

    // ----------------------------------------------------------------
    // Time bases
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_tb
        logic [6:0] pre_q;
        logic [14:0] cnt_q;
        logic ovf_q;
        logic on;
        logic [2:0] pre_sel;
        logic [2:0] per_sel;
        logic [6:0] pmask;
        logic [14:0] cmask;
        logic pre_tick;
        logic src;

        assign on = tbc_q[i][tbgi_pkg::TBC_ON_BIT];
        assign pre_sel = (i == 0) ? tbc_q[i][tbgi_pkg::TBC_PRE_LSB +: 3] : 3'h0;
        assign per_sel = tbc_q[i][tbgi_pkg::TBC_PER_LSB +: 3];

        always_comb begin
            if (i == 0 && i_deep_sleep) begin
                src = lirc_rise;
            end else if (psc_q[i] == tbgi_pkg::SEL_SYS) begin
                src = 1'b1;
            end else if (psc_q[i] == tbgi_pkg::SEL_DIV4) begin
                src = div4_tick;
            end else begin
                src = sub_rise;
            end
        end

        assign pmask = 7'((8'h01 << pre_sel) - 8'h01);
        assign cmask = 15'((16'h0001 << (tbgi_pkg::PER_BASE + 32'(per_sel))) - 16'h0001);
        assign pre_tick = src && ((pre_q & pmask) == pmask);

        always_ff @(posedge i_mclk) begin
            if (i_reset) begin
                pre_q <= 7'h00;
                cnt_q <= 15'h0000;
                ovf_q <= 1'b0;
            end else if (i_ce) begin
                if (!on) begin
                    pre_q <= 7'h00;
                    cnt_q <= 15'h0000;
                    ovf_q <= 1'b0;
                end else begin
                    ovf_q <= pre_tick && ((cnt_q & cmask) == cmask);
                    if (src) begin
                        pre_q <= pre_tick ? 7'h00 : pre_q + 7'h01;
                    end
                    if (pre_tick) begin
                        cnt_q <= ((cnt_q & cmask) == cmask) ? 15'h0000 : cnt_q + 15'h0001;
                    end
                end
            end
        end

        assign src_tick[i] = src;
        assign tb_ovf[i] = ovf_q;
        assign tb_cnt[i] = cnt_q;
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            psc_q[0] <= tbgi_pkg::PSC_RST;
            psc_q[1] <= tbgi_pkg::PSC_RST;
            tbc_q[0] <= tbgi_pkg::TBC_RST;
            tbc_q[1] <= tbgi_pkg::TBC_RST;
            thr_q <= TXLEN_W'(tbgi_pkg::THR_RST);
        end else if (i_ce && wr_fire && i_avs_byteenable[0]) begin
            unique case (i_avs_address)
                tbgi_pkg::ADDR_PSC0: psc_q[0] <= i_avs_writedata[1:0];
                tbgi_pkg::ADDR_PSC1: psc_q[1] <= i_avs_writedata[1:0];
                tbgi_pkg::ADDR_TBC0: tbc_q[0] <= i_avs_writedata[7:0] & tbgi_pkg::TBC0_WMASK;
                tbgi_pkg::ADDR_TBC1: tbc_q[1] <= i_avs_writedata[7:0] & tbgi_pkg::TBC1_WMASK;
                tbgi_pkg::ADDR_THR: thr_q <= i_avs_writedata[TXLEN_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Global enable, time-base flags, group enables and flags
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            global_q <= 1'b0;
        end else if (i_ce) begin
            if (i_irq_ack) begin
                global_q <= 1'b0;
            end else if (i_return_from_irq) begin
                global_q <= 1'b1;
            end else if (wr_fire && i_avs_byteenable[0] && i_avs_address == tbgi_pkg::ADDR_IRQ) begin
                global_q <= i_avs_writedata[tbgi_pkg::IRQ_GLOBAL_BIT];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            tick_en_q <= 2'h0;
            grp_en_q <= 3'h0;
        end else if (i_ce && wr_fire && i_avs_byteenable[0] && i_avs_address == tbgi_pkg::ADDR_IRQ) begin
            tick_en_q <= i_avs_writedata[tbgi_pkg::IRQ_TICKEN_LSB +: 2];
            grp_en_q <= i_avs_writedata[tbgi_pkg::IRQ_GRPEN_LSB +: 3];
        end
    end

    // Group set: a fresh member event, or members still pending after service
    always_comb begin
        for (int g = 0; g < 3; g++) begin
            grp_set[g] = (|(mem_evt[g] & tbgi_pkg::GRP_MEMBER_MASK[3*g +: 3]))
                || ((|mem_flag_q[g]) && !grp_flag_q[g]);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            tick_flag_q <= 2'h0;
            grp_flag_q <= 3'h0;
        end else if (i_ce) begin
            // Hardware set wins over software write and service clear
            if (wr_fire && i_avs_byteenable[1] && i_avs_address == tbgi_pkg::ADDR_IRQ) begin
                tick_flag_q <= i_avs_writedata[tbgi_pkg::IRQ_TICKF_LSB +: 2] | tb_ovf;
                grp_flag_q <= i_avs_writedata[tbgi_pkg::IRQ_GRPF_LSB +: 3] | grp_set;
            end else begin
                tick_flag_q <= (tick_flag_q & ~ack_hot[1:0]) | tb_ovf;
                grp_flag_q <= (grp_flag_q & ~ack_hot[4:2]) | grp_set;
            end
        end
    end

    // ----------------------------------------------------------------
    // Member flags and enables; never cleared by service
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            for (int g = 0; g < 3; g++) begin
                mem_flag_q[g] <= 3'h0;
                mem_en_q[g] <= 3'h0;
            end
        end else if (i_ce) begin
            for (int g = 0; g < 3; g++) begin
                if (wr_fire && i_avs_byteenable[0] && i_avs_address == 6'(tbgi_pkg::ADDR_GRP0 + 6'(4 * g))) begin
                    mem_en_q[g] <= i_avs_writedata[tbgi_pkg::GRP_EN_LSB +: 3] & tbgi_pkg::GRP_MEMBER_MASK[3*g +: 3];
                    mem_flag_q[g] <= (i_avs_writedata[tbgi_pkg::GRP_FLAG_LSB +: 3] | mem_evt[g])
                        & tbgi_pkg::GRP_MEMBER_MASK[3*g +: 3];
                end else begin
                    mem_flag_q[g] <= mem_flag_q[g] | (mem_evt[g] & tbgi_pkg::GRP_MEMBER_MASK[3*g +: 3]);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Vectoring towards the sequencer
    // ----------------------------------------------------------------
    always_comb begin
        pend[0] = tick_flag_q[0] && tick_en_q[0];
        pend[1] = tick_flag_q[1] && tick_en_q[1];
        for (int g = 0; g < 3; g++) begin
            pend[2 + g] = grp_flag_q[g] && grp_en_q[g] && (|(mem_flag_q[g] & mem_en_q[g]));
        end
        vec_d = vec_q;
        for (int k = 4; k >= 0; k--) begin
            if (pend[k]) begin
                vec_d = tbgi_pkg::tbgi_vec_t'(3'(k));
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            req_q <= 1'b0;
            vec_q <= tbgi_pkg::TBGI_VEC_TICK0;
        end else if (i_ce) begin
            req_q <= global_q && !i_stack_full && (|pend) && !i_irq_ack;
            if (!i_irq_ack) begin
                vec_q <= vec_d;
            end
        end
    end

    // Wake on any flag going high, enable bits ignored
    assign any_rise = (|(tb_ovf & ~tick_flag_q)) || (|(grp_set & ~grp_flag_q))
        || (|(mem_evt[0] & ~mem_flag_q[0] & tbgi_pkg::GRP_MEMBER_MASK[2:0]))
        || (|(mem_evt[1] & ~mem_flag_q[1] & tbgi_pkg::GRP_MEMBER_MASK[5:3]))
        || (|(mem_evt[2] & ~mem_flag_q[2]));

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wake_q <= 1'b0;
        end else if (i_ce) begin
            wake_q <= any_rise;
        end
    end

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then a single answer cycle
    // ----------------------------------------------------------------
    always_comb begin
        unique case (i_avs_address)
            tbgi_pkg::ADDR_PSC0: rdata_d = 32'(psc_q[0]);
            tbgi_pkg::ADDR_PSC1: rdata_d = 32'(psc_q[1]);
            tbgi_pkg::ADDR_TBC0: rdata_d = 32'(tbc_q[0]);
            tbgi_pkg::ADDR_TBC1: rdata_d = 32'(tbc_q[1]);
            tbgi_pkg::ADDR_IRQ: rdata_d = 32'({grp_flag_q, tick_flag_q, 2'h0, grp_en_q, tick_en_q, global_q});
            tbgi_pkg::ADDR_GRP0: rdata_d = 32'({mem_flag_q[0], 1'b0, mem_en_q[0]});
            tbgi_pkg::ADDR_GRP1: rdata_d = 32'({mem_flag_q[1], 1'b0, mem_en_q[1]});
            tbgi_pkg::ADDR_GRP2: rdata_d = 32'({mem_flag_q[2], 1'b0, mem_en_q[2]});
            tbgi_pkg::ADDR_THR: rdata_d = 32'(thr_q);
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (i_ce) begin
            wait_q <= !((i_avs_read || i_avs_write) && wait_q);
            if (i_avs_read && wait_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_irq_req = req_q;
    assign o_irq_vector = vec_q;
    assign o_wake = wake_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    a_tick_flag_set: assert property ((i_ce && tb_ovf[0]) |=> tick_flag_q[0])
        else $error("time base 0 overflow did not set its flag");
    a_req_gating: assert property ((o_irq_req && $past(i_ce)) |-> ($past(global_q) && !$past(i_stack_full)))
        else $error("request raised without global enable or with full stack");
    a_tick_ack_clr: assert property ((i_ce && i_irq_ack && o_irq_vector == tbgi_pkg::TBGI_VEC_TICK0
        && !tb_ovf[0] && !wr_fire) |=> (!tick_flag_q[0] && !global_q))
        else $error("time base 0 service did not clear flag and global enable");
    a_psc0_sys: assert property ((!i_deep_sleep && psc_q[0] == tbgi_pkg::SEL_SYS) |-> src_tick[0])
        else $error("prescaler 0 system clock selection not ticking");
    a_psc1_sub: assert property ((psc_q[1][1]) |-> (src_tick[1] == sub_rise))
        else $error("prescaler 1 sub clock selection wrong");
    a_deep_src: assert property (i_deep_sleep |-> (src_tick[0] == lirc_rise))
        else $error("time base 0 not on low-speed oscillator in deep sleep");
    a_tb_off_zero: assert property ((i_ce && !tbc_q[0][tbgi_pkg::TBC_ON_BIT]) |=> (tb_cnt[0] == 15'h0000
        && !tb_ovf[0]))
        else $error("disabled time base 0 not held at zero");
    a_tb1_period: assert property ((i_ce && !wr_fire && tbc_q[1] == 8'h80 && src_tick[1] && tb_cnt[1] == 15'h00ff)
        |=> (tb_ovf[1] && tb_cnt[1] == 15'h0000))
        else $error("time base 1 shortest period not 256 ticks");
    a_grp_set: assert property ((i_ce && i_burst_done) |=> (grp_flag_q[2] && mem_flag_q[2][0]))
        else $error("burst completion did not set member and group flags");
    a_grp_ack: assert property ((i_ce && i_irq_ack && o_irq_vector == tbgi_pkg::TBGI_VEC_GRP2
        && grp_flag_q[2] && mem_evt[2] == 3'h0 && !wr_fire) |=> (!grp_flag_q[2] && !global_q))
        else $error("group 2 service did not clear group flag");
    a_member_kept: assert property ((i_ce && i_irq_ack && mem_flag_q[2][0] && !wr_fire) |=> mem_flag_q[2][0])
        else $error("member flag cleared by service");
    a_margin_set: assert property ((i_ce && margin_rise) |=> mem_flag_q[2][1])
        else $error("margin drop did not set its flag");
    a_wake_pulse: assert property ((i_ce && low_rise && !mem_flag_q[2][2]) |=> o_wake)
        else $error("rising low-supply flag did not wake");
    a_return_from_irq_instr_sets: assert property ((i_ce && i_return_from_irq && !i_irq_ack) |=> global_q)
        else $error("return from interrupt did not set global enable");

    c_tick0_served: cover property (o_irq_req && o_irq_vector == tbgi_pkg::TBGI_VEC_TICK0 && i_irq_ack);
    c_grp2_served: cover property (o_irq_req && o_irq_vector == tbgi_pkg::TBGI_VEC_GRP2 && i_irq_ack);
    c_grp_reraise: cover property (i_irq_ack ##1 !grp_flag_q[2] ##1 grp_flag_q[2]);
    c_wake_seen: cover property (o_wake);

endmodule

// ### tbgi_seq_model.sv
// Core sequencer stand-in: acknowledges a pending request, promptly or slowly.
// Assumes the block's clock and reset; the bench pulses the return itself.
module tbgi_seq_model (
    input logic i_mclk,
    input logic i_reset,
    input logic i_irq_req,
    input tbgi_pkg::tbgi_vec_t i_irq_vector,
    input logic i_slow,
    output logic o_irq_ack,
    output tbgi_pkg::tbgi_vec_t o_vec_q,
    output int o_taken
);
    int wait_q;
    // --------------------------------
    // Ack one cycle; never twice
    // --------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_reset || o_irq_ack || !i_irq_req) begin
            o_irq_ack <= 1'b0;
            wait_q <= 0;
        end else if (wait_q >= (i_slow ? 5 : 0)) begin
            o_irq_ack <= 1'b1;
            wait_q <= 0;
        end else begin
            wait_q <= wait_q + 1;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_taken <= 0;
        end else if (o_irq_ack) begin
            o_taken <= o_taken + 1;
            o_vec_q <= i_irq_vector;
        end
    end
endmodule

// ### time_base_and_grouped_irq_bench.sv
// Self-checking bench for tbgi_core.
// Assumes the sequencer model answers the interrupt request.
module time_base_and_grouped_irq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 0, i_reset = 1, rd = 0, wr = 0, ack, ret = 0, low = 0, burst = 0, full = 0, slow = 0;
    logic waitreq, req, wake;
    logic sub = 0, deep = 0, losc = 0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] match = 4'h0;
    logic [7:0] fill = 8'h0a;
    tbgi_pkg::tbgi_vec_t vec, vec_q;
    int taken, n_mismatch = 0, checks = 0, cyc = 0, wakes = 0;
    always #2.5 i_mclk = ~i_mclk;
    tbgi_core uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_sub_clock(sub), .i_low_speed_osc(losc), .i_deep_sleep(deep),
        .i_timer_match(match), .i_low_supply(low), .i_tx_fill_len(fill), .i_burst_done(burst),
        .i_stack_full(full), .i_irq_ack(ack), .i_return_from_irq(ret), .o_irq_req(req),
        .o_irq_vector(vec), .o_wake(wake));
    tbgi_seq_model core (.i_mclk(i_mclk), .i_reset(i_reset), .i_irq_req(req), .i_irq_vector(vec),
        .i_slow(slow), .o_irq_ack(ack), .o_vec_q(vec_q), .o_taken(taken));
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        sub <= ~sub;
        if (deep) losc <= ~losc;
        if (wake === 1'b1) wakes <= wakes + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_mclk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic put(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic get(input string nm, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, exp, q);
    endtask
    task automatic take(input tbgi_pkg::tbgi_vec_t v, input int lim, output int t);
        int n0;
        n0 = taken;
        t = 0;
        while (taken == n0 && t < lim) begin
            @(posedge i_mclk);
            t++;
        end
        chk("taken", 32'(n0 + 1), 32'(taken));
        chk("vector", 32'(v), 32'(vec_q));
    endtask
    task automatic t_regs();
        get("psc0", 6'h00, 32'h0);
        get("tbc0", 6'h08, 32'h0);
        get("tbc1", 6'h0c, 32'h0);
        get("unmapped", 6'h24, 32'h0);
        put(6'h0c, 32'h0000_00ff);
        get("tbc1 mask", 6'h0c, 32'h0000_0087);
        put(6'h0c, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_tick(input logic [5:0] psc, input logic [31:0] sel, input logic [31:0] ctl,
        input logic [31:0] irq, input tbgi_pkg::tbgi_vec_t v, input int lo);
        int t;
        put(psc, sel);
        put(6'h10, irq);
        put(psc + 6'h08, ctl);
        take(v, lo + 20, t);
        chk("period", 32'h1, 32'(t >= lo && t <= lo + 10));
        put(psc + 6'h08, 32'h0);
        get("irq after take", 6'h10, irq & ~32'h1);
        $display("test tick done");
    endtask
    task automatic t_group0();
        int t, w0;
        w0 = wakes;
        full <= 1'b1;
        put(6'h14, 32'h0000_0001);
        put(6'h10, 32'h0000_0009);
        @(posedge i_mclk) match <= 4'h1;
        @(posedge i_mclk) match <= 4'h0;
        repeat (20) @(posedge i_mclk);
        get("blocked", 6'h10, 32'h0000_0409);
        chk("wake", 32'(w0 + 1), 32'(wakes));
        full <= 1'b0;
        take(tbgi_pkg::TBGI_VEC_GRP0, 20, t);
        get("after service", 6'h10, 32'h0000_0408);
        get("member kept", 6'h14, 32'h0000_0011);
        put(6'h14, 32'h0000_0001);
        put(6'h10, 32'h0000_0008);
        @(posedge i_mclk) ret <= 1'b1;
        @(posedge i_mclk) ret <= 1'b0;
        get("return", 6'h10, 32'h0000_0009);
        $display("test group0 done");
    endtask
    task automatic t_member(input int k, input logic [31:0] flg);
        int t;
        put(6'h1c, 32'h0000_0007);
        put(6'h10, 32'h0000_0021);
        @(posedge i_mclk);
        case (k)
            0: burst <= 1'b1;
            1: fill <= 8'h05;
            default: low <= 1'b1;
        endcase
        @(posedge i_mclk) burst <= 1'b0;
        take(tbgi_pkg::TBGI_VEC_GRP2, 40, t);
        get("grp2 flags", 6'h1c, flg);
        put(6'h1c, 32'h0000_0007);
        $display("test member done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_regs();
        t_tick(6'h00, 32'h0, 32'h0000_0080, 32'h3, tbgi_pkg::TBGI_VEC_TICK0, 256);
        t_tick(6'h00, 32'h0, 32'h0000_0091, 32'h3, tbgi_pkg::TBGI_VEC_TICK0, 1024);
        t_tick(6'h04, 32'h1, 32'h0000_0081, 32'h5, tbgi_pkg::TBGI_VEC_TICK1, 2048);
        t_tick(6'h04, 32'h2, 32'h0000_0080, 32'h5, tbgi_pkg::TBGI_VEC_TICK1, 512);
        deep <= 1'b1;
        t_tick(6'h00, 32'h0, 32'h0000_0080, 32'h3, tbgi_pkg::TBGI_VEC_TICK0, 512);
        deep <= 1'b0;
        t_group0();
        put(6'h20, 32'h0000_0008);
        slow <= 1'b1;
        t_member(0, 32'h0000_0017);
        t_member(1, 32'h0000_0027);
        t_member(2, 32'h0000_0047);
        tally_and_finish();
    end
endmodule
